// [field_check.sv]
// decoding and checking of the part B fields of a complete block
`timescale 1ns/1ps
module field_check (
  // block contents
  input wire logic [7:0] tag_i,
  input wire logic [23:0] addr_i,
  input wire logic [47:0] pb_i,
  // configuration
  input wire logic [3:0] exp_version_i,
  input wire logic burst_cut_area_i,
  // results
  output prepit_pkg::blk_info_t info_o,
  output prepit_pkg::blk_err_t err_o
);
  import prepit_pkg::*;

  function automatic disk_kind_t class_kind(input logic unres, input logic [5:0] cls);
    if (cls == APP_SL_CLASS0) begin
      return KIND_SL_CLASS0;
    end else if (unres) begin
      return KIND_RESERVED;
    end else if (cls == APP_DL_CLASS0) begin
      return KIND_DL_CLASS0;
    end
    return KIND_SPECIAL;
  endfunction

  logic [7:0] app;
  logic [7:0] phys;
  logic [7:0] vx;
  logic [7:0] lay;
  logic [23:0] lra;
  logic [23:0] lra_min;
  logic t0;
  logic t1;
  logic t2;

  assign app = pb_i[47:40];
  assign phys = pb_i[39:32];
  assign lra = pb_i[31:8];
  assign vx = pb_i[7:0];
  assign lay = pb_i[23:16];
  assign t0 = tag_i == TAG_LAYER;
  assign t1 = tag_i == TAG_ZONE0;
  assign t2 = tag_i == TAG_ZONE1;
  assign lra_min = burst_cut_area_i ? LRA1_MIN_BCA : LRA1_MIN;

  always_comb begin
    info_o.tag = tag_i;
    info_o.layer1 = lay[LAYER_BIT];
    info_o.unrestricted = app[APP_USE_BIT];
    info_o.kind = class_kind(app[APP_USE_BIT], app[5:0]);
    info_o.app_class = app[5:0];
    info_o.disk_80mm = phys[PHYS_SIZE_BIT];
    info_o.phase_change = phys[PHYS_PC_BIT];
    info_o.lra = lra;
    info_o.version = vx[7:4];
  end

  // the zone limits are not bounds on block addresses, so no address is held against them
  always_comb begin
    err_o = '0;
    err_o.tag = tag_i > TAG_MAX;
    err_o.app = t1 && (app[APP_ZERO_BIT] || info_o.kind == KIND_SL_CLASS0
                       || info_o.kind == KIND_RESERVED);
    err_o.phys = t1 && ((phys & PHYS_FIX_MASK) != PHYS_FIX_VAL);
    err_o.ext = t1 && (vx[3:0] != EXT_CODE);
    err_o.ver = t1 && (vx[7:4] != exp_version_i);
    err_o.zero = (t2 && (app != ZERO_BYTE || phys != ZERO_BYTE || vx != ZERO_BYTE))
               || (t0 && pb_i[15:0] != {ZERO_BYTE, ZERO_BYTE});
    err_o.lra_low = t2 && (lra < lra_min);
    err_o.layer = t0 && (lay[6:0] != 7'h00);
    err_o.echo = t0 && (pb_i[47:24] != addr_i);
  end
endmodule // field_check

// [prepit_detector_model.sv]
// detector model: takes built frames, hands them back as detected frames
`timescale 1ns/1ps
module prepit_detector_model (
  // clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // built frames
  input prepit_pkg::frame_t frame_i,
  input wire logic vld_i,
  output logic rdy_o,
  // detected frames
  output prepit_pkg::frame_t det_frame_o,
  output logic det_vld_o
);
  import prepit_pkg::*;
  initial rdy_o = 1'b1;
  initial det_vld_o = 1'b0;
  initial det_frame_o = '0;
  // slow mode accepts every other cycle
  always @(negedge clk_i) begin
    rdy_o <= slow_i ? ~rdy_o : 1'b1;
  end
  // number passed as is, unchecked; idle lines show the inverse
  always @(posedge clk_i) begin
    det_vld_o <= vld_i & rdy_o;
    det_frame_o <= (vld_i & rdy_o) ? frame_i : ~det_frame_o;
  end
endmodule // prepit_detector_model

// [prepit_info_block_codec.sv]
// builder and parser of 16-frame pre-pit information blocks
`timescale 1ns/1ps
module prepit_info_block_codec (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // block build request
  input wire logic tx_start_i,
  input prepit_pkg::blk_fields_t tx_fields_i,
  output logic tx_busy_o,
  output logic tx_done_o,
  // built frame stream
  output prepit_pkg::frame_t tx_frame_o,
  output logic tx_frame_vld_o,
  input wire logic tx_frame_rdy_i,
  // detected frame stream
  input prepit_pkg::frame_t rx_frame_i,
  input wire logic rx_frame_vld_i,
  // configuration
  input wire logic [3:0] exp_version_i,
  input wire logic burst_cut_area_i,
  // parse results
  output logic [23:0] rx_addr_o,
  output logic rx_addr_vld_o,
  output prepit_pkg::blk_info_t rx_info_o,
  output prepit_pkg::field_vld_t rx_field_vld_o,
  output prepit_pkg::blk_err_t rx_err_o,
  output logic rx_err_vld_o
);
  import prepit_pkg::*;

  // ==========================================================
  // shared helpers

  // parity byte that belongs at frame n, taken from a remainder
  function automatic logic [7:0] par_byte(input logic [23:0] p, input logic [3:0] n);
    logic [7:0] b;
    unique case (n)
      FN_PARA0, FN_PARB0: b = p[23:16];
      FN_PARA0 + 4'h1, FN_PARB1: b = p[15:8];
      default: b = p[7:0];
    endcase
    return b;
  endfunction

  // frames whose byte enters the remainder
  function automatic logic rs_feeds(input logic [3:0] n);
    return (n < FN_PARA0) || (n >= FN_TAG && n < FN_PARB0);
  endfunction

  // frames whose byte is a parity byte
  function automatic logic is_parity(input logic [3:0] n);
    return (n >= FN_PARA0 && n <= FN_PARA2) || n >= FN_PARB0;
  endfunction

  // ==========================================================
  // builder

  typedef enum {B_IDLE, B_SEND} bld_state_t;

  bld_state_t bld_ff;
  blk_fields_t tx_fld_ff;
  frame_t tx_frame_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_vld_ff;
  logic tx_done_ff;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [23:0] tx_par;

  // while sending, a new frame is loaded whenever the output slot is free or being taken
  assign tx_load = (bld_ff == B_SEND) && (!tx_vld_ff || tx_frame_rdy_i);

  // byte for each frame number of the block being built
  always_comb begin
    tx_byte = ZERO_BYTE;
    if (is_parity(tx_cnt_ff)) begin
      tx_byte = par_byte(tx_par, tx_cnt_ff);
    end else begin
      unique case (tx_cnt_ff)
        FN_ADDR0: tx_byte = tx_fld_ff.addr[23:16];
        FN_ADDR0 + 4'h1: tx_byte = tx_fld_ff.addr[15:8];
        FN_ADDR0 + 4'h2: tx_byte = tx_fld_ff.addr[7:0];
        FN_TAG: tx_byte = tx_fld_ff.tag;
        FN_APP: begin
          if (tx_fld_ff.tag == TAG_ZONE0) begin
            tx_byte = {1'b0, tx_fld_ff.unrestricted, tx_fld_ff.app_class};
          end else if (tx_fld_ff.tag == TAG_LAYER) begin
            tx_byte = tx_fld_ff.addr[23:16];
          end
        end
        FN_PHYS: begin
          if (tx_fld_ff.tag == TAG_ZONE0) begin
            tx_byte = PHYS_FIX_VAL
                    | ({7'h00, tx_fld_ff.disk_80mm} << PHYS_SIZE_BIT)
                    | ({7'h00, tx_fld_ff.phase_change} << PHYS_PC_BIT);
          end else if (tx_fld_ff.tag == TAG_LAYER) begin
            tx_byte = tx_fld_ff.addr[15:8];
          end
        end
        FN_LRA0: begin
          if (tx_fld_ff.tag == TAG_LAYER) begin
            tx_byte = tx_fld_ff.addr[7:0];
          end else if (tx_fld_ff.tag <= TAG_ZONE1) begin
            tx_byte = tx_fld_ff.lra[23:16];
          end
        end
        FN_LAYER: begin
          if (tx_fld_ff.tag == TAG_LAYER) begin
            tx_byte = {tx_fld_ff.layer1, 7'h00};
          end else if (tx_fld_ff.tag <= TAG_ZONE1) begin
            tx_byte = tx_fld_ff.lra[15:8];
          end
        end
        FN_LAYER + 4'h1: begin
          if (tx_fld_ff.tag == TAG_ZONE0 || tx_fld_ff.tag == TAG_ZONE1) begin
            tx_byte = tx_fld_ff.lra[7:0];
          end
        end
        FN_VX: begin
          if (tx_fld_ff.tag == TAG_ZONE0) begin
            tx_byte = {tx_fld_ff.version, EXT_CODE};
          end
        end
        default: tx_byte = ZERO_BYTE;
      endcase
    end
  end

  rs_parity3 u_tx_rs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(tx_load && (tx_cnt_ff == FN_ADDR0 || tx_cnt_ff == FN_TAG)),
    .en_i(tx_load && rs_feeds(tx_cnt_ff)),
    .byte_i(tx_byte),
    .par_o(tx_par)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bld_ff <= B_IDLE;
      tx_cnt_ff <= FN_ADDR0;
    end else if (bld_ff == B_IDLE && tx_start_i) begin
      bld_ff <= B_SEND;
      tx_cnt_ff <= FN_ADDR0;
    end else if (tx_load) begin
      tx_cnt_ff <= tx_cnt_ff + 4'h1;
      if (tx_cnt_ff == FN_LAST) begin
        bld_ff <= B_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_fld_ff <= '0;
    end else if (bld_ff == B_IDLE && tx_start_i) begin
      tx_fld_ff <= tx_fields_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_frame_ff <= '0;
      tx_vld_ff <= 1'b0;
    end else if (tx_load) begin
      tx_frame_ff <= '{sync: tx_cnt_ff == FN_ADDR0, num: tx_cnt_ff, data: tx_byte};
      tx_vld_ff <= 1'b1;
    end else if (tx_frame_rdy_i) begin
      tx_vld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_done_ff <= 1'b0;
    end else begin
      tx_done_ff <= tx_load && tx_cnt_ff == FN_LAST;
    end
  end

  assign tx_busy_o = bld_ff == B_SEND;
  assign tx_done_o = tx_done_ff;
  assign tx_frame_o = tx_frame_ff;
  assign tx_frame_vld_o = tx_vld_ff;

  // ==========================================================
  // parser

  typedef enum {P_HUNT, P_BLOCK} prs_state_t;

  prs_state_t prs_ff;
  logic [3:0] rx_exp_ff;
  logic rx_pa_bad_ff;
  logic rx_pb_bad_ff;
  logic [7:0] rx_tag_ff;
  logic [23:0] rx_abuf_ff;
  logic [47:0] rx_pb_ff;
  logic rx_start;
  logic rx_inseq;
  logic rx_take;
  logic rx_break;
  logic rx_pmis;
  logic [23:0] rx_par;
  blk_info_t chk_info;
  blk_err_t chk_err;
  blk_err_t nxt_err;
  field_vld_t nxt_fvld;
  logic rx_a_end;
  logic rx_b_end;

  // the frame number is trusted as is; only its order is checked
  assign rx_start = rx_frame_vld_i && rx_frame_i.sync && rx_frame_i.num == FN_ADDR0;
  assign rx_inseq = rx_frame_vld_i && !rx_frame_i.sync && prs_ff == P_BLOCK
                  && rx_frame_i.num == rx_exp_ff;
  assign rx_take = rx_start || rx_inseq;
  assign rx_break = prs_ff == P_BLOCK && rx_frame_vld_i && (!rx_take || rx_exp_ff != FN_ADDR0 && rx_start);
  assign rx_pmis = rx_frame_i.data != par_byte(rx_par, rx_frame_i.num);
  assign rx_a_end = rx_inseq && rx_frame_i.num == FN_PARA2;
  assign rx_b_end = rx_inseq && rx_frame_i.num == FN_LAST;

  rs_parity3 u_rx_rs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(rx_take && (rx_frame_i.num == FN_ADDR0 || rx_frame_i.num == FN_TAG)),
    .en_i(rx_take && rs_feeds(rx_frame_i.num)),
    .byte_i(rx_frame_i.data),
    .par_o(rx_par)
  );

  field_check u_chk (
    .tag_i(rx_tag_ff),
    .addr_i(rx_abuf_ff),
    .pb_i(rx_pb_ff),
    .exp_version_i(exp_version_i),
    .burst_cut_area_i(burst_cut_area_i),
    .info_o(chk_info),
    .err_o(chk_err)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prs_ff <= P_HUNT;
      rx_exp_ff <= FN_ADDR0;
    end else if (rx_take) begin
      rx_exp_ff <= rx_frame_i.num + 4'h1;
      prs_ff <= (rx_frame_i.num == FN_LAST) ? P_HUNT : P_BLOCK;
    end else if (rx_break) begin
      prs_ff <= P_HUNT;
    end
  end

  // block contents, parity verdicts collected frame by frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_abuf_ff <= RS_RST;
      rx_tag_ff <= ZERO_BYTE;
      rx_pb_ff <= '0;
      rx_pa_bad_ff <= 1'b0;
      rx_pb_bad_ff <= 1'b0;
    end else if (rx_take) begin
      if (rx_frame_i.num < FN_PARA0) begin
        rx_abuf_ff <= {rx_abuf_ff[15:0], rx_frame_i.data};
      end
      if (rx_frame_i.num == FN_TAG) begin
        rx_tag_ff <= rx_frame_i.data;
      end
      if (rx_frame_i.num > FN_TAG && rx_frame_i.num < FN_PARB0) begin
        rx_pb_ff <= {rx_pb_ff[39:0], rx_frame_i.data};
      end
      if (rx_frame_i.num == FN_ADDR0) begin
        rx_pa_bad_ff <= 1'b0;
      end else if (rx_frame_i.num >= FN_PARA0 && rx_frame_i.num <= FN_PARA2) begin
        rx_pa_bad_ff <= rx_pa_bad_ff || rx_pmis;
      end
      if (rx_frame_i.num == FN_ADDR0) begin
        rx_pb_bad_ff <= 1'b0;
      end else if (rx_frame_i.num >= FN_PARB0) begin
        rx_pb_bad_ff <= rx_pb_bad_ff || rx_pmis;
      end
    end
  end

  // error word and field strobes for this cycle
  always_comb begin
    nxt_err = '0;
    nxt_fvld = '0;
    nxt_err.seq = rx_break;
    nxt_err.par_a = rx_a_end && (rx_pa_bad_ff || rx_pmis);
    if (rx_b_end) begin
      nxt_err.par_b = rx_pb_bad_ff || rx_pmis;
      if (!nxt_err.par_b) begin
        nxt_err.tag = chk_err.tag;
        nxt_err.app = chk_err.app;
        nxt_err.phys = chk_err.phys;
        nxt_err.ext = chk_err.ext;
        nxt_err.ver = chk_err.ver;
        nxt_err.zero = chk_err.zero;
        nxt_err.lra_low = chk_err.lra_low;
        nxt_err.layer = chk_err.layer;
        nxt_err.echo = chk_err.echo;
        nxt_fvld.tag = 1'b1;
        nxt_fvld.app = rx_tag_ff == TAG_ZONE0;
        nxt_fvld.phys = rx_tag_ff == TAG_ZONE0;
        nxt_fvld.ver = rx_tag_ff == TAG_ZONE0;
        nxt_fvld.lra = rx_tag_ff == TAG_ZONE0 || rx_tag_ff == TAG_ZONE1;
        nxt_fvld.layer = rx_tag_ff == TAG_LAYER;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_err_o <= '0;
      rx_err_vld_o <= 1'b0;
      rx_field_vld_o <= '0;
    end else begin
      rx_err_o <= nxt_err;
      rx_err_vld_o <= |nxt_err;
      rx_field_vld_o <= nxt_fvld;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_addr_o <= RS_RST;
      rx_addr_vld_o <= 1'b0;
    end else begin
      rx_addr_vld_o <= rx_a_end && !(rx_pa_bad_ff || rx_pmis);
      if (rx_a_end) begin
        rx_addr_o <= rx_abuf_ff;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_info_o <= '0;
    end else if (rx_b_end) begin
      rx_info_o <= chk_info;
    end
  end
endmodule // prepit_info_block_codec

// [prepit_info_block_codec_assertions.sv]
// port checks of the pre-pit information block codec
`timescale 1ns/1ps
module prepit_info_block_codec_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // builder side
  input wire logic tx_start_i,
  input wire logic tx_busy_o,
  input wire logic tx_done_o,
  input prepit_pkg::frame_t tx_frame_o,
  input wire logic tx_frame_vld_o,
  input wire logic tx_frame_rdy_i,
  // parser side
  input prepit_pkg::frame_t rx_frame_i,
  input wire logic rx_frame_vld_i,
  input wire logic rx_addr_vld_o,
  input prepit_pkg::field_vld_t rx_field_vld_o,
  input prepit_pkg::blk_err_t rx_err_o,
  input wire logic rx_err_vld_o
);
  import prepit_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // helper: block type of the frames now leaving
  logic [7:0] tag_ff;
  wire logic take = tx_frame_vld_o & tx_frame_rdy_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tag_ff <= 8'h00;
    end else if (take && tx_frame_o.num == FN_TAG) begin
      tag_ff <= tx_frame_o.data;
    end
  end
  // ==========================================================
  // assertions
  sequence s_start;
    tx_start_i && !tx_busy_o && !tx_frame_vld_o;
  endsequence
  sequence s_first;
    tx_frame_vld_o && tx_frame_o.sync && tx_frame_o.num == FN_ADDR0;
  endsequence
  a_busy_rises: assert property (s_start |=> tx_busy_o)
    else $error("busy did not rise");
  a_first_frame: assert property (s_start |-> ##2 s_first)
    else $error("first frame wrong");
  a_frame_hold: assert property (tx_frame_vld_o && !tx_frame_rdy_i |=>
    tx_frame_vld_o && $stable(tx_frame_o)) else $error("stalled frame moved");
  a_sync_only0: assert property (tx_frame_vld_o |->
    tx_frame_o.sync == (tx_frame_o.num == FN_ADDR0)) else $error("sync bit wrong");
  a_num_steps: assert property (take && tx_frame_o.num != FN_LAST |=>
    tx_frame_vld_o && tx_frame_o.num == $past(tx_frame_o.num) + 4'h1)
    else $error("frame number skipped");
  a_ext_zero: assert property (tx_frame_vld_o && tx_frame_o.num == FN_VX |->
    tx_frame_o.data[3:0] == EXT_CODE) else $error("extension not zero");
  a_phys_fixed: assert property (tx_frame_vld_o && tx_frame_o.num == FN_PHYS &&
    tag_ff == TAG_ZONE0 |-> (tx_frame_o.data & PHYS_FIX_MASK) == PHYS_FIX_VAL)
    else $error("physical fixed bits wrong");
  a_addr_timing: assert property (rx_addr_vld_o |-> $past(rx_frame_vld_i) &&
    $past(rx_frame_i.num) == FN_PARA2) else $error("address strobe misplaced");
  a_fields_timing: assert property (|rx_field_vld_o |-> $past(rx_frame_vld_i) &&
    $past(rx_frame_i.num) == FN_LAST) else $error("field strobe misplaced");
  a_err_flags: assert property (rx_err_vld_o == (|rx_err_o))
    else $error("error strobe and flags disagree");
  a_done_pulse: assert property (tx_done_o |-> !tx_busy_o ##1 !tx_done_o)
    else $error("done not a single pulse");
endmodule // prepit_info_block_codec_assertions

// [prepit_pkg.sv]
// shared constants and types of the pre-pit information block codec
package prepit_pkg;

  // ==========================================================
  // frame layout
  localparam int FRAME_W = 13;
  localparam logic [3:0] FN_ADDR0 = 4'h0;
  localparam logic [3:0] FN_PARA0 = 4'h3;
  localparam logic [3:0] FN_PARA2 = 4'h5;
  localparam logic [3:0] FN_TAG = 4'h6;
  localparam logic [3:0] FN_APP = 4'h7;
  localparam logic [3:0] FN_PHYS = 4'h8;
  localparam logic [3:0] FN_LRA0 = 4'h9;
  localparam logic [3:0] FN_LAYER = 4'hA;
  localparam logic [3:0] FN_VX = 4'hC;
  localparam logic [3:0] FN_PARB0 = 4'hD;
  localparam logic [3:0] FN_PARB1 = 4'hE;
  localparam logic [3:0] FN_LAST = 4'hF;

  // ==========================================================
  // block type tags
  localparam logic [7:0] TAG_LAYER = 8'h00;
  localparam logic [7:0] TAG_ZONE0 = 8'h01;
  localparam logic [7:0] TAG_ZONE1 = 8'h02;
  localparam logic [7:0] TAG_MAX = 8'h05;

  // ==========================================================
  // byte fields, byte bit 7 is frame bit 5
  localparam int APP_ZERO_BIT = 7;
  localparam int APP_USE_BIT = 6;
  localparam logic [5:0] APP_DL_CLASS0 = 6'h02;
  localparam logic [5:0] APP_SL_CLASS0 = 6'h00;
  localparam logic [7:0] PHYS_FIX_MASK = 8'hDB;
  localparam logic [7:0] PHYS_FIX_VAL = 8'h93;
  localparam int PHYS_SIZE_BIT = 5;
  localparam int PHYS_PC_BIT = 2;
  localparam int LAYER_BIT = 7;
  localparam logic [3:0] EXT_CODE = 4'h0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [23:0] LRA1_MIN = 24'h00332A;
  localparam logic [23:0] LRA1_MIN_BCA = 24'h003370;

  // ==========================================================
  // parity code
  localparam logic [7:0] GF_POLY = 8'h1D;
  localparam logic [7:0] RS_G2 = 8'h07;
  localparam logic [7:0] RS_G1 = 8'h0E;
  localparam logic [7:0] RS_G0 = 8'h08;
  localparam logic [23:0] RS_RST = 24'h000000;

  // ==========================================================
  // types
  typedef struct packed {
    logic sync;
    logic [3:0] num;
    logic [7:0] data;
  } frame_t;

  typedef enum logic [1:0] {KIND_DL_CLASS0, KIND_SL_CLASS0, KIND_SPECIAL, KIND_RESERVED}
    disk_kind_t;

  typedef struct packed {
    logic [7:0] tag;
    logic [23:0] addr;
    logic layer1;
    logic unrestricted;
    logic [5:0] app_class;
    logic disk_80mm;
    logic phase_change;
    logic [23:0] lra;
    logic [3:0] version;
  } blk_fields_t;

  typedef struct packed {
    logic [7:0] tag;
    logic layer1;
    logic unrestricted;
    disk_kind_t kind;
    logic [5:0] app_class;
    logic disk_80mm;
    logic phase_change;
    logic [23:0] lra;
    logic [3:0] version;
  } blk_info_t;

  typedef struct packed {
    logic seq;
    logic par_a;
    logic par_b;
    logic tag;
    logic app;
    logic phys;
    logic ext;
    logic ver;
    logic zero;
    logic lra_low;
    logic layer;
    logic echo;
  } blk_err_t;

  typedef struct packed {
    logic tag;
    logic app;
    logic phys;
    logic lra;
    logic ver;
    logic layer;
  } field_vld_t;

endpackage

// [rs_parity3.sv]
// three-byte reed-solomon remainder generator, one byte per enable
`timescale 1ns/1ps
module rs_parity3 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // byte feed
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [7:0] byte_i,
  // remainder, first parity byte on top
  output logic [23:0] par_o
);
  import prepit_pkg::*;

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = p ^ x;
      end
      x = x[7] ? ((x << 1) ^ GF_POLY) : (x << 1);
    end
    return p;
  endfunction

  logic [23:0] rem_ff;
  logic [23:0] base;
  logic [7:0] fb;

  // clear and feed in one cycle starts a fresh remainder
  always_comb begin
    base = clr_i ? RS_RST : rem_ff;
    fb = byte_i ^ base[23:16];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_ff <= RS_RST;
    end else if (en_i) begin
      rem_ff <= {base[15:8] ^ gf_mul(fb, RS_G2), base[7:0] ^ gf_mul(fb, RS_G1),
                 gf_mul(fb, RS_G0)};
    end else if (clr_i) begin
      rem_ff <= RS_RST;
    end
  end

  assign par_o = rem_ff;
endmodule // rs_parity3

// [tb_top.sv]
// testbench of the pre-pit information block codec
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  import prepit_pkg::*;
  // ==========================================================
  // signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tx_start_i = 1'b0;
  blk_fields_t tx_fields_i = '0;
  logic tx_busy_o, tx_done_o, tx_frame_vld_o, tx_frame_rdy_i, rx_addr_vld_o, rx_err_vld_o;
  frame_t tx_frame_o, det_frame;
  frame_t inj_frame = '0;
  logic det_vld, ended;
  logic inj = 1'b0;
  logic inj_vld = 1'b0;
  logic slow_i = 1'b0;
  logic [3:0] exp_version_i = 4'h3;
  logic burst_cut_area_i = 1'b0;
  logic [23:0] rx_addr_o;
  blk_info_t rx_info_o;
  field_vld_t rx_field_vld_o, fv_seen;
  blk_err_t rx_err_o, err_seen;
  logic [7:0] got [16];
  int nfr;
  int failures = 0;
  int tests_run = 0;
  wire frame_t rx_frame_i = inj ? inj_frame : det_frame;
  wire logic rx_frame_vld_i = inj ? inj_vld : det_vld;
  always #12.5 clk_i = ~clk_i;
  // ==========================================================
  // design and detector
  prepit_info_block_codec prepit_info_block_codec_i (.clk_i, .rst_i, .tx_start_i,
    .tx_fields_i, .tx_busy_o, .tx_done_o, .tx_frame_o, .tx_frame_vld_o, .tx_frame_rdy_i,
    .rx_frame_i, .rx_frame_vld_i, .exp_version_i, .burst_cut_area_i, .rx_addr_o,
    .rx_addr_vld_o, .rx_info_o, .rx_field_vld_o, .rx_err_o, .rx_err_vld_o);
  prepit_detector_model prepit_detector_model_i (.clk_i, .slow_i, .frame_i(tx_frame_o),
    .vld_i(tx_frame_vld_o), .rdy_o(tx_frame_rdy_i), .det_frame_o(det_frame),
    .det_vld_o(det_vld));
  // collects what one block produced
  always @(posedge clk_i) begin
    if (tx_start_i && !tx_busy_o) begin
      nfr <= 0;
      fv_seen <= '0;
      err_seen <= '0;
      ended <= 1'b0;
    end else begin
      nfr <= nfr + int'(det_vld);
      fv_seen <= fv_seen | rx_field_vld_o;
      err_seen <= err_seen | rx_err_o;
      ended <= ended | rx_err_vld_o | (|rx_field_vld_o);
    end
    if (det_vld) begin
      got[det_frame.num] <= det_frame.data;
    end
  end
  // ==========================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // syndromes of the received codeword at alpha^0..2, all zero when the parity fits
  function automatic logic [23:0] synd(input int lo, input int hi);
    logic [7:0] s [3];
    s = '{8'h00, 8'h00, 8'h00};
    for (int j = lo; j <= hi; j++) begin
      for (int k = 0; k < 3; k++) begin
        for (int m = 0; m < k; m++) begin
          s[k] = {s[k][6:0], 1'b0} ^ (s[k][7] ? GF_POLY : 8'h00);
        end
        s[k] = s[k] ^ got[j];
      end
    end
    return {s[0], s[1], s[2]};
  endfunction
  // builds one block, pokes a refused start mid-block, waits for the parse
  task automatic run(input blk_fields_t f, input logic slow);
    @(negedge clk_i);
    tx_fields_i = f;
    slow_i = slow;
    tx_start_i = 1'b1;
    // the start edge clears the collector before ended is tested
    @(negedge clk_i);
    tx_start_i = 1'b0;
    for (int n = 0; n < 200 && !ended; n++) begin
      @(negedge clk_i);
      tx_start_i = (n == 3);
    end
    if (!ended) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic t_zone0();
    run('{TAG_ZONE0, 24'hFCFFFE, 1'b0, 1'b0, 6'h02, 1'b1, 1'b1, 24'hFDD10A, 4'h3}, 1'b1);
    `CHK(nfr, 16)
    `CHK({got[0], got[1], got[2]}, 24'hFCFFFE)
    `CHK(got[6], 8'h01)
    `CHK(got[7], 8'h02)
    `CHK(got[8], 8'hB7)
    `CHK({got[9], got[10], got[11]}, 24'hFDD10A)
    `CHK(got[12], 8'h30)
    `CHK(synd(0, 5), 24'h000000)
    `CHK(synd(6, 15), 24'h000000)
    `CHK(rx_addr_o, 24'hFCFFFE)
    `CHK(rx_info_o.kind, KIND_DL_CLASS0)
    `CHK({rx_info_o.disk_80mm, rx_info_o.phase_change}, 2'b11)
    `CHK(fv_seen, 6'h3E)
    `CHK(err_seen, 12'h000)
  endtask
  task automatic t_zone1();
    logic [23:0] lim [4] = '{24'h00332A, 24'h003329, 24'h003370, 24'h00336F};
    for (int k = 0; k < 4; k++) begin
      burst_cut_area_i = k[1];
      run('{TAG_ZONE1, 24'h00FFFF, 1'b1, 1'b0, 6'h02, 1'b1, 1'b0, lim[k], 4'h3}, 1'b0);
      `CHK(got[6], 8'h02)
      `CHK({got[7], got[8], got[12]}, 24'h000000)
      `CHK({got[9], got[10], got[11]}, lim[k])
      `CHK(rx_info_o.lra, lim[k])
      `CHK(err_seen.lra_low, k[0])
    end
    burst_cut_area_i = 1'b0;
  endtask
  task automatic t_app();
    logic [9:0] cs [5] = '{{1'b0, 6'h02, KIND_DL_CLASS0, 1'b0},
      {1'b0, 6'h00, KIND_SL_CLASS0, 1'b1}, {1'b0, 6'h05, KIND_SPECIAL, 1'b0},
      {1'b1, 6'h00, KIND_SL_CLASS0, 1'b1}, {1'b1, 6'h07, KIND_RESERVED, 1'b1}};
    for (int k = 0; k < 5; k++) begin
      run('{TAG_ZONE0, 24'hFDFFFF, 1'b0, cs[k][9], cs[k][8:3], 1'b0, 1'b0, 24'hFDD10A,
        4'h3}, 1'b0);
      `CHK(got[7], {1'b0, cs[k][9:3]})
      `CHK(rx_info_o.kind, cs[k][2:1])
      `CHK(err_seen.app, cs[k][0])
    end
    exp_version_i = 4'h9;
    run('{TAG_ZONE0, 24'hFDFFFF, 1'b0, 1'b0, 6'h02, 1'b0, 1'b0, 24'hFDD10A, 4'h3}, 1'b0);
    `CHK(err_seen.ver, 1'b1)
    exp_version_i = 4'h3;
  endtask
  task automatic t_layer();
    for (int k = 0; k < 2; k++) begin
      run('{TAG_LAYER, 24'hFFD001, k[0], 1'b0, 6'h00, 1'b0, 1'b0, 24'h0, 4'h0}, 1'b0);
      `CHK(got[10], {k[0], 7'h00})
      `CHK(rx_info_o.layer1, k[0])
      `CHK(err_seen, 12'h000)
    end
  endtask
  // part A with zero parity under a non-zero address, then frame 2 out of order
  task automatic t_seq();
    inj = 1'b1;
    for (int j = 0; j < 7; j++) begin
      @(negedge clk_i);
      if (j == 6) `CHK({rx_addr_vld_o, rx_err_vld_o, rx_err_o}, 14'h1400)
      inj_vld = 1'b1;
      inj_frame = '{j == 0, 4'(j == 6 ? 2 : j), (j == 0) ? 8'h12 : 8'h00};
    end
    @(negedge clk_i);
    inj_vld = 1'b0;
    `CHK({rx_err_vld_o, rx_err_o}, 13'h1800)
    repeat (2) @(negedge clk_i);
    `CHK(err_seen.seq, 1'b1)
    inj = 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    `CHK({tx_busy_o, tx_frame_vld_o, rx_err_vld_o}, 3'b000)
    t_zone0();
    t_zone1();
    t_app();
    t_layer();
    t_seq();
    t_zone0();
    tally_and_finish();
  end
endmodule // tb_top
bind prepit_info_block_codec prepit_info_block_codec_assertions chk_i (.clk_i, .rst_i,
  .tx_start_i, .tx_busy_o, .tx_done_o, .tx_frame_o, .tx_frame_vld_o, .tx_frame_rdy_i,
  .rx_frame_i, .rx_frame_vld_i, .rx_addr_vld_o, .rx_field_vld_o, .rx_err_o, .rx_err_vld_o);
